/* File: hdl/ppm_defines.vh */
/*
 * Constants for the port pin function mux: configuration field positions,
 * mode codes, bit positions and reset values.
 * Assumes it is included by bare name from hdl/ design files.
 */
`ifndef PPM_DEFINES_VH
`define PPM_DEFINES_VH

// ----------------------------------------
// Configuration field positions
// ----------------------------------------
`define PPM_PA_FOUR_LSB      0
`define PPM_PA_FIVE_LSB      4
`define PPM_PA_HC_LSB        8
`define PPM_PB_ONE_LSB       4
`define PPM_CFG_W            4

// ----------------------------------------
// Pin configuration field codes
// ----------------------------------------
`define PPM_CFG_ANALOG       4'h0
`define PPM_CFG_OUT          4'h1
`define PPM_CFG_IN           4'h4
`define PPM_CFG_OUT_ALT      4'h9
`define PPM_CFG_OUT_ALT_OD   4'hd

// ----------------------------------------
// Serial controller one modes
// ----------------------------------------
`define PPM_SC_MODE_OFF      2'h0
`define PPM_SC_MODE_UART     2'h1
`define PPM_SC_MODE_SPI      2'h2
`define PPM_SC_MODE_TWI      2'h3

// ----------------------------------------
// Timer bits
// ----------------------------------------
`define PPM_T1_CH3_EN_BIT    8
`define PPM_T2_CH1_EN_BIT    0
`define PPM_T2_REMAP_CH1_BIT 4

// ----------------------------------------
// Reset values and interrupt select width
// ----------------------------------------
`define PPM_BOOT_RST         1'h0
`define PPM_IRQ_SEL_W        5

`endif

/* File: hdl/ppm_pin_sync.v */
/*
 * Two flip-flop synchroniser for a bus of pin inputs.
 * Assumes the inputs come from pads outside the i_clk domain.
 */
`timescale 1ns/1ps
`default_nettype none

module ppm_pin_sync #(
	parameter W = 4
) (
	input  wire         i_clk,
	input  wire         i_rst,
	input  wire [W-1:0] i_async,
	output wire [W-1:0] o_sync
);

	reg [W-1:0] meta_r;
	reg [W-1:0] sync_r;

	// First stage read only by second stage
	always @(posedge i_clk) begin
		if (i_rst) begin
			meta_r <= {W{1'b0}};
			sync_r <= {W{1'b0}};
		end else begin
			meta_r <= i_async;
			sync_r <= meta_r;
		end
	end

	assign o_sync = sync_r;

endmodule

`default_nettype wire

/* File: hdl/ppm_pin_mux.v */
/*
 * Pin function mux for four port pins: two port A pins shared by analog
 * inputs, packet trace and CPU trace; a high-current port A pin carrying a
 * timer one channel; a port B pin shared by serial controller one and a
 * remappable timer two channel. Also external interrupt pin selection and
 * boot-select capture.
 * Assumes configuration values come from registers on i_clk; pad inputs are
 * asynchronous and are synchronised here.
 */
// Behaviour
// - Pin four analog selects analog input four
// - Pin five analog selects analog input five
// - Packet trace frame on pin four conditions
// - Packet trace data on pin five conditions
// - CPU trace bit two on pin four
// - CPU trace bit three on pin five
// - Sample boot select at reset release
// - Timer one channel three drives high-current pin
// - Timer one channel three input fixed
// - Serial one only without remapped and enabled timer two
// - SPI slave or master data out
// - Two-wire data open-drain bidirectional
// - UART transmit on port B pin
// - Timer two channel one when remapped
// - External interrupts from any digital pin
`timescale 1ns/1ps
`default_nettype none
`include "ppm_defines.vh"

module ppm_pin_mux #(
	parameter NPIN  = 24,
	parameter SEL_W = `PPM_IRQ_SEL_W
) (
	input  wire              i_clk,
	input  wire              i_rst,
	// Configuration
	input  wire [15:0]       i_port_a_high_config_reg,
	input  wire [15:0]       i_port_b_low_config_reg,
	input  wire [15:0]       i_timer_one_channel_enable_reg,
	input  wire [15:0]       i_timer_two_channel_enable_reg,
	input  wire [7:0]        i_timer_two_remap_reg,
	input  wire [1:0]        i_serial_one_mode_select,
	input  wire              i_serial_one_spi_master,
	input  wire              i_core_trace_en,
	input  wire              i_core_trace_sync4,
	input  wire              i_packet_trace_port_en,
	input  wire [SEL_W-1:0]  i_ext_irq_third_pin_select,
	input  wire [SEL_W-1:0]  i_ext_irq_fourth_pin_select,
	// Peripheral sources
	input  wire              i_packet_trace_frame,
	input  wire              i_packet_trace_serial_out,
	input  wire              i_cpu_trace_bit_two,
	input  wire              i_cpu_trace_bit_three,
	input  wire              i_timer_one_channel_three,
	input  wire              i_timer_two_channel_one,
	input  wire              i_serial_one_spi_slave_out,
	input  wire              i_serial_one_spi_master_out,
	input  wire              i_serial_one_twowire_data,
	input  wire              i_serial_one_uart_transmit,
	// Port data registers, bit order: a4, a5, a_hc, b1
	input  wire [3:0]        i_gpio_out,
	input  wire [NPIN-1:0]   i_digital_pins_in,
	input  wire              i_external_reset_n,
	// Pads, bit order: a4, a5, a_hc, b1
	input  wire [3:0]        i_pad_in,
	output reg  [3:0]        o_pad_out,
	output reg  [3:0]        o_pad_oe,
	output reg  [3:0]        o_pad_analog,
	// Results
	output reg               o_analog_input_four,
	output reg               o_analog_input_five,
	output wire [3:0]        o_gpio_in,
	output wire              o_timer_one_channel_three_in,
	output wire              o_serial_one_twowire_data_in,
	output reg               o_ext_irq_third_line,
	output reg               o_ext_irq_fourth_line,
	output reg               o_factory_info_monitor
);

	// Bit order of every four-bit pad bus
	localparam P_A4 = 0;
	localparam P_A5 = 1;
	localparam P_HC = 2;
	localparam P_B1 = 3;

	// ----------------------------------------
	// Field decode
	// ----------------------------------------
	function [3:0] fld;
		input [15:0] cfg;
		input integer lsb;
		begin
			fld = cfg[lsb +: 4];
		end
	endfunction

	// Open-drain alternate counts as alternate too
	function is_alt;
		input [3:0] f;
		begin
			is_alt = (f == `PPM_CFG_OUT_ALT) || (f == `PPM_CFG_OUT_ALT_OD);
		end
	endfunction

	// Each pin's four-bit field, picked once here
	wire [3:0] cfg_a4 = fld(i_port_a_high_config_reg, `PPM_PA_FOUR_LSB);
	wire [3:0] cfg_a5 = fld(i_port_a_high_config_reg, `PPM_PA_FIVE_LSB);
	wire [3:0] cfg_hc = fld(i_port_a_high_config_reg, `PPM_PA_HC_LSB);
	wire [3:0] cfg_b1 = fld(i_port_b_low_config_reg, `PPM_PB_ONE_LSB);

	// ----------------------------------------
	// Pad and pin synchronisers
	// ----------------------------------------
	wire [3:0]      pad_s;
	wire [NPIN-1:0] dig_s;
	wire            rstn_s;

	// One bus keeps reset, pads and pins equally delayed
	ppm_pin_sync #(.W(NPIN + 5)) u_sync (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_async ({i_external_reset_n, i_pad_in, i_digital_pins_in}),
		.o_sync  ({rstn_s, pad_s, dig_s})
	);

	assign o_gpio_in = pad_s;
	assign o_timer_one_channel_three_in = pad_s[P_HC];
	assign o_serial_one_twowire_data_in = pad_s[P_B1];

	// ----------------------------------------
	// Qualifiers
	// ----------------------------------------
	// Core trace owns pins four and five whenever on
	wire pti_ok   = !i_core_trace_en && i_packet_trace_port_en;
	wire trace_ok = i_core_trace_en && i_core_trace_sync4;
	wire t1c3_en  = i_timer_one_channel_enable_reg[`PPM_T1_CH3_EN_BIT];
	wire t2c1_en  = i_timer_two_channel_enable_reg[`PPM_T2_CH1_EN_BIT];
	wire t2_remap = i_timer_two_remap_reg[`PPM_T2_REMAP_CH1_BIT];
	// Timer two owns pin only when remapped and enabled
	wire sc1_ok   = !t2c1_en || !t2_remap;

	// ----------------------------------------
	// Output selection
	// ----------------------------------------
	// Next pad drive, registered below
	reg [3:0] out_nxt;
	reg [3:0] oe_nxt;
	reg [3:0] an_nxt;

	always @* begin
		out_nxt = i_gpio_out;
		oe_nxt  = {(cfg_b1 == `PPM_CFG_OUT), (cfg_hc == `PPM_CFG_OUT),
			(cfg_a5 == `PPM_CFG_OUT), (cfg_a4 == `PPM_CFG_OUT)};
		an_nxt  = 4'h0;

		if (cfg_a4 == `PPM_CFG_ANALOG) begin
			an_nxt[P_A4] = 1'b1;
		end else if (is_alt(cfg_a4)) begin
			// Core trace ahead of packet trace
			oe_nxt[P_A4] = 1'b0;
			out_nxt[P_A4] = 1'b0;
			if (trace_ok) begin
				oe_nxt[P_A4]  = 1'b1;
				out_nxt[P_A4] = i_cpu_trace_bit_two;
			end else if (pti_ok) begin
				oe_nxt[P_A4]  = 1'b1;
				out_nxt[P_A4] = i_packet_trace_frame;
			end
		end

		if (cfg_a5 == `PPM_CFG_ANALOG) begin
			an_nxt[P_A5] = 1'b1;
		end else if (is_alt(cfg_a5)) begin
			oe_nxt[P_A5]  = 1'b0;
			out_nxt[P_A5] = 1'b0;
			if (trace_ok) begin
				oe_nxt[P_A5]  = 1'b1;
				out_nxt[P_A5] = i_cpu_trace_bit_three;
			end else if (pti_ok) begin
				oe_nxt[P_A5]  = 1'b1;
				out_nxt[P_A5] = i_packet_trace_serial_out;
			end
		end

		if (is_alt(cfg_hc)) begin
			oe_nxt[P_HC]  = t1c3_en;
			out_nxt[P_HC] = t1c3_en & i_timer_one_channel_three;
		end

		// Port B pin one: timer two first, then serial one
		if (is_alt(cfg_b1)) begin
			oe_nxt[P_B1]  = 1'b0;
			out_nxt[P_B1] = 1'b0;
			if (!sc1_ok) begin
				oe_nxt[P_B1]  = 1'b1;
				out_nxt[P_B1] = i_timer_two_channel_one;
			end else begin
				case (i_serial_one_mode_select)
				`PPM_SC_MODE_SPI: begin
					oe_nxt[P_B1]  = 1'b1;
					out_nxt[P_B1] = i_serial_one_spi_master ?
						i_serial_one_spi_master_out : i_serial_one_spi_slave_out;
				end
				`PPM_SC_MODE_TWI: begin
					oe_nxt[P_B1]  = !i_serial_one_twowire_data;
					out_nxt[P_B1] = 1'b0;
				end
				`PPM_SC_MODE_UART: begin
					oe_nxt[P_B1]  = 1'b1;
					out_nxt[P_B1] = i_serial_one_uart_transmit;
				end
				default: begin
					// Serial one off: alternate pin floats
					oe_nxt[P_B1]  = 1'b0;
					out_nxt[P_B1] = 1'b0;
				end
				endcase
			end
		end
	end

	// ----------------------------------------
	// Registered pad drive
	// ----------------------------------------
	// Avoids pad glitches while config fields change
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_pad_out           <= 4'h0;
			o_pad_oe            <= 4'h0;
			o_pad_analog        <= 4'h0;
			o_analog_input_four <= 1'b0;
			o_analog_input_five <= 1'b0;
		end else begin
			o_pad_out           <= out_nxt;
			o_pad_oe            <= oe_nxt;
			o_pad_analog        <= an_nxt;
			o_analog_input_four <= an_nxt[P_A4];
			o_analog_input_five <= an_nxt[P_A5];
		end
	end

	// ----------------------------------------
	// External interrupt selection
	// ----------------------------------------
	// Out-of-range select reads low rather than wrapping
	function pick_pin;
		input [NPIN-1:0]  pins;
		input [SEL_W-1:0] sel;
		begin
			pick_pin = (sel < NPIN) ? pins[sel] : 1'b0;
		end
	endfunction

	always @(posedge i_clk) begin
		if (i_rst) begin
			o_ext_irq_third_line  <= 1'b0;
			o_ext_irq_fourth_line <= 1'b0;
		end else begin
			o_ext_irq_third_line  <= pick_pin(dig_s, i_ext_irq_third_pin_select);
			o_ext_irq_fourth_line <= pick_pin(dig_s, i_ext_irq_fourth_pin_select);
		end
	end

	// ----------------------------------------
	// Boot select capture
	// ----------------------------------------
	// Boot select is active low on pin five
	// One sample at release, not a window: simple and glitch free
	reg rstn_d_r;

	always @(posedge i_clk) begin
		if (i_rst) begin
			rstn_d_r               <= 1'b0;
			o_factory_info_monitor <= `PPM_BOOT_RST;
		end else begin
			rstn_d_r <= rstn_s;
			// Held until the next release of external reset
			if (rstn_s && !rstn_d_r) begin
				o_factory_info_monitor <= !pad_s[P_A5];
			end
		end
	end

endmodule

`default_nettype wire

/* File: tb/ppm_mux_sva.sv */
/* Assertions on the pad routing of ppm_pin_mux.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module ppm_mux_sva (
	input wire logic        i_clk,
	input wire logic        i_rst,
	input wire logic [15:0] i_port_a_high_config_reg,
	input wire logic [15:0] i_port_b_low_config_reg,
	input wire logic [15:0] i_timer_one_channel_enable_reg,
	input wire logic [15:0] i_timer_two_channel_enable_reg,
	input wire logic [7:0]  i_timer_two_remap_reg,
	input wire logic [1:0]  i_serial_one_mode_select,
	input wire logic        i_core_trace_en,
	input wire logic        i_core_trace_sync4,
	input wire logic        i_packet_trace_port_en,
	input wire logic        i_packet_trace_frame,
	input wire logic        i_cpu_trace_bit_two,
	input wire logic        i_timer_one_channel_three,
	input wire logic        i_timer_two_channel_one,
	input wire logic        i_serial_one_uart_transmit,
	input wire logic        i_serial_one_twowire_data,
	input wire logic [3:0]  i_gpio_out,
	input wire logic [3:0]  i_pad_in,
	input wire logic [3:0]  o_pad_out,
	input wire logic [3:0]  o_pad_oe,
	input wire logic        o_timer_one_channel_three_in
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	wire [3:0] fa = i_port_a_high_config_reg[3:0];
	wire [3:0] fh = i_port_a_high_config_reg[11:8];
	wire [3:0] fb = i_port_b_low_config_reg[7:4];
	wire       t1 = i_timer_one_channel_enable_reg[8];
	wire       t2 = i_timer_two_remap_reg[4] & i_timer_two_channel_enable_reg[0];
	function automatic logic alt(input logic [3:0] f);
		return f == 4'h9 || f == 4'hd;
	endfunction
	wire       sc = alt(fb) & ~t2;
	// Two clean edges fill the pad synchroniser
	sequence s_run2;
		!i_rst ##1 !i_rst;
	endsequence
	chk_gpio_drive: assert property (fa == 4'h1 |=> o_pad_oe[0] && o_pad_out[0] == $past(i_gpio_out[0]))
		else $error("gpio drive");
	chk_packet_frame: assert property (alt(fa) && !i_core_trace_en && i_packet_trace_port_en
		|=> o_pad_oe[0] && o_pad_out[0] == $past(i_packet_trace_frame)) else $error("frame");
	chk_cpu_trace: assert property (alt(fa) && i_core_trace_en && i_core_trace_sync4
		|=> o_pad_oe[0] && o_pad_out[0] == $past(i_cpu_trace_bit_two)) else $error("trace");
	chk_timer_one: assert property (alt(fh) |=> o_pad_oe[2] == $past(t1)
		&& o_pad_out[2] == ($past(t1) & $past(i_timer_one_channel_three))) else $error("timer one");
	chk_timer_two: assert property (alt(fb) && t2
		|=> o_pad_oe[3] && o_pad_out[3] == $past(i_timer_two_channel_one)) else $error("timer two");
	chk_uart_tx: assert property (sc && i_serial_one_mode_select == 2'h1
		|=> o_pad_oe[3] && o_pad_out[3] == $past(i_serial_one_uart_transmit)) else $error("uart");
	chk_twi_drain: assert property (sc && i_serial_one_mode_select == 2'h3
		|=> !o_pad_out[3] && o_pad_oe[3] == !$past(i_serial_one_twowire_data)) else $error("twi");
	chk_t1_input: assert property (s_run2 |=> o_timer_one_channel_three_in == $past(i_pad_in[2], 2))
		else $error("t1 input");
endmodule
bind ppm_pin_mux ppm_mux_sva u_sva (.i_clk, .i_rst, .i_port_a_high_config_reg, .i_port_b_low_config_reg,
	.i_timer_one_channel_enable_reg, .i_timer_two_channel_enable_reg, .i_timer_two_remap_reg,
	.i_serial_one_mode_select, .i_core_trace_en, .i_core_trace_sync4, .i_packet_trace_port_en,
	.i_packet_trace_frame, .i_cpu_trace_bit_two, .i_timer_one_channel_three, .i_timer_two_channel_one,
	.i_serial_one_uart_transmit, .i_serial_one_twowire_data, .i_gpio_out, .i_pad_in, .o_pad_out,
	.o_pad_oe, .o_timer_one_channel_three_in);
`default_nettype wire

/* File: tb/ppm_board.sv */
/* Board model of the four pads.
   Assumes pad enable is high while the mux drives. */
`timescale 1ns/1ps
`default_nettype none
module ppm_board (
	input  wire logic [3:0] i_out,
	input  wire logic [3:0] i_oe,
	input  wire logic [3:0] i_drv,
	input  wire logic [3:0] i_drv_en,
	output wire logic [3:0] o_pad
);
	// open-drain wired and
	// Pull-ups hold idle pads high; a low driver always wins
	assign o_pad = (i_out | ~i_oe) & (i_drv | ~i_drv_en);
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
/* Self-checking bench for ppm_pin_mux with the board model.
   Assumes pad outputs follow inputs one edge later. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        clk, rst, ms, cte, cs4, pte, ern, a4, a5, t1i, q3, q4, fim, twi;
	logic [15:0] ca, cb, t1e, t2e;
	logic [7:0]  rm;
	logic [1:0]  md;
	logic [4:0]  s3, s4;
	logic [9:0]  sv;
	logic [3:0]  go, drv, den, pad, po, poe, pan, gin;
	logic [23:0] dp;
	int          error_cnt, tests_run;
	ppm_pin_mux dut (.i_clk(clk), .i_rst(rst), .i_port_a_high_config_reg(ca), .i_port_b_low_config_reg(cb),
		.i_timer_one_channel_enable_reg(t1e), .i_timer_two_channel_enable_reg(t2e), .i_timer_two_remap_reg(rm),
		.i_serial_one_mode_select(md), .i_serial_one_spi_master(ms), .i_core_trace_en(cte),
		.i_core_trace_sync4(cs4), .i_packet_trace_port_en(pte), .i_ext_irq_third_pin_select(s3),
		.i_ext_irq_fourth_pin_select(s4), .i_packet_trace_frame(sv[0]), .i_packet_trace_serial_out(sv[1]),
		.i_cpu_trace_bit_two(sv[2]), .i_cpu_trace_bit_three(sv[3]), .i_timer_one_channel_three(sv[4]),
		.i_timer_two_channel_one(sv[5]), .i_serial_one_spi_slave_out(sv[6]), .i_serial_one_spi_master_out(sv[7]),
		.i_serial_one_twowire_data(sv[8]), .i_serial_one_uart_transmit(sv[9]), .i_gpio_out(go),
		.i_digital_pins_in(dp), .i_external_reset_n(ern), .i_pad_in(pad), .o_pad_out(po), .o_pad_oe(poe),
		.o_pad_analog(pan), .o_analog_input_four(a4), .o_analog_input_five(a5), .o_gpio_in(gin),
		.o_timer_one_channel_three_in(t1i), .o_serial_one_twowire_data_in(twi), .o_ext_irq_third_line(q3),
		.o_ext_irq_fourth_line(q4), .o_factory_info_monitor(fim));
	ppm_board board (.i_out(po), .i_oe(poe), .i_drv(drv), .i_drv_en(den), .o_pad(pad));
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (3000) @(posedge clk);
		error_cnt++;
		close_out();
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("mismatches %0d of %0d checks", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		{rst, ern, ms, cte, cs4, pte} <= 6'h20;
		{ca, cb, t1e, t2e, rm, md} <= {16'h4444, 16'h0040, 42'h0};
		{s3, s4, sv, go, drv, den, dp} <= {5'h00, 5'h01, 10'h000, 4'h0, 4'h0, 4'h2, 24'h000000};
		wt(15);
		@(posedge clk);
		rst <= 0;
		wt(4);
		@(posedge clk);
		ern <= 1;
		wt(3);
		chk(fim, 1);
		@(posedge clk);
		{ern, drv[1]} <= 2'b01;
		wt(4);
		@(posedge clk);
		ern <= 1;
		wt(3);
		chk(fim, 0);
		@(posedge clk);
		ca <= 16'h4400;
		wt(1);
		chk({a4, a5, pan[1:0], poe[1:0]}, 8'h3c);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			{cte, cs4, pte, ca, sv} <= {i[2:0], 16'h44d9, 10'h009};
			wt(1);
			chk({poe[1:0], po[1:0]}, i[2:1] == 3 ? 8'he : (!i[2] && i[0]) ? 8'hd : 8'h0);
		end
		@(posedge clk);
		{ca, go, den} <= {16'h4141, 4'b0101, 4'h0};
		wt(3);
		chk({poe[2:0], po[2:0], gin[1]}, 8'h5b);
		for (int j = 0; j < 2; j++) begin
			@(posedge clk);
			{ca[11:8], t1e[8], sv[4], den[2]} <= {4'h9, j[0], 1'b1, !j[0]};
			wt(3);
			chk({poe[2], po[2], t1i}, {5'h0, {3{j[0]}}});
		end
		for (int m = 0; m < 4; m++)
			for (int g = 0; g < 3; g++)
				for (int s = 0; s < 2; s++) begin
					@(posedge clk);
					cb <= m == 3 ? 16'h00d0 : 16'h0090;
					{md, ms, rm[4], t2e[0], sv[9:5]} <= {m[1:0], s[0], g != 0, g != 1, 1'b1, s[0], s[0], !s[0], 1'b0};
					wt(1);
					chk({poe[3], po[3]}, g == 2 ? 8'h2 : (m == 1 || m == 2) ? 8'h3 :
						(m == 3 && s == 0) ? 8'h2 : 8'h0);
				end
		@(posedge clk);
		{rm[4], sv[8]} <= 2'b00;
		wt(3);
		chk({twi, gin[3]}, 8'h0);
		@(posedge clk);
		sv[8] <= 1'b1;
		wt(3);
		chk({twi, gin[3]}, 8'h3);
		@(posedge clk);
		{s3, s4, dp} <= {5'd7, 5'd24, 24'h000080};
		wt(4);
		chk({q3, q4}, 8'h2);
		@(posedge clk);
		{s3, s4, dp} <= {5'd7, 5'd23, 24'h800000};
		wt(4);
		chk({q3, q4}, 8'h1);
		close_out();
	end
endmodule
`default_nettype wire
